/* tb/cmpd_event_sink.sv */
// Far-side model: interrupt controller, ADC trigger and PWM fault input.
// Assumes pulses and levels arrive on the block clock.
module cmpd_event_sink (
	input wire logic mclk_i,
	input wire logic irq_i,
	input wire logic adc_i,
	input wire logic pwm_i,
	input wire logic filt_i,
	output int pulses_o,
	output int faults_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic irq_q = 1'b0;
	initial pulses_o = 0;
	initial faults_o = 0;
	always @(posedge mclk_i) begin
		irq_q <= irq_i;
		if (irq_i === 1'b1 && irq_q !== 1'b1)
			pulses_o <= pulses_o + 1;
		// Wide requests, or irq/adc and pwm/filt disagreements, are counted as faults here
		if ((irq_i === 1'b1 && irq_q === 1'b1) || irq_i !== adc_i || pwm_i !== filt_i)
			faults_o <= faults_o + 1;
	end
endmodule

/* tb/test_comparator_digital_control.sv */
// Testbench for the comparator control block: AXI4-Lite tasks and event checks.
// Assumes cmpd_top, its package and the event sink model.
module test_comparator_digital_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i, rst_n_i, cmp_raw_i, sleep_i, idle_i, group_stop_i;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, pad;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	cmpd_pkg::cmpd_analog_t cfg;
	logic stop_o, filt, irq, adc, pwm, wake;
	int err_count, checked, pulses, faults, base;
	cmpd_top #(.FILT_CYCLES(2)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmp_raw_i(cmp_raw_i),
		.sleep_i(sleep_i), .idle_i(idle_i), .group_stop_i(group_stop_i),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .analog_cfg_o(cfg),
		.pad_dig_disable_o(pad), .stop_in_idle_o(stop_o), .filtered_o(filt),
		.irq_pulse_o(irq), .adc_trig_o(adc), .pwm_fault_o(pwm), .wake_async_o(wake));
	cmpd_event_sink sink (.mclk_i(mclk_i), .irq_i(irq), .adc_i(adc), .pwm_i(pwm),
		.filt_i(filt), .pulses_o(pulses), .faults_o(faults));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// Handshakes are sampled mid-cycle, so registered outputs are settled
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] rp;
		@(posedge mclk_i);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(negedge mclk_i);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rp = bresp;
			@(posedge mclk_i);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (tb !== 1'b1);
		bready <= 1'b0;
		chk_resp("bresp", er, tb === 1'b1 ? rp : 2'bxx);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] rp;
		@(posedge mclk_i);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(negedge mclk_i);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			rp = rresp;
			@(posedge mclk_i);
			if (ta) arvalid <= 1'b0;
		end while (tr !== 1'b1);
		rready <= 1'b0;
		chk_resp("rresp", er, tr === 1'b1 ? rp : 2'bxx);
		chk_val("rdata", exp, d);
	endtask
	task automatic wait_filt(input logic v);
		int n;
		n = 0;
		while (filt !== v && n < 30) begin
			@(negedge mclk_i);
			n++;
		end
		chk_val("filtered", {31'h0, v}, {31'h0, filt});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, err_count + faults);
		if (err_count == 0 && faults == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		{rst_n_i, cmp_raw_i, sleep_i, idle_i, group_stop_i} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		err_count = 0;
		checked = 0;
		cyc(4);
		rst_n_i <= 1'b1;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h0, 2'h0);
		chk_val("cfg", 32'h0, {15'h0, cfg});
		rd(4'h8, 32'h0, 2'h2);
		wr(4'hc, 32'hffff, 2'h2);
		wr(4'h0, 32'h7fff, 2'h0);
		rd(4'h0, 32'h21e3, 2'h0);
		wr(4'h4, 32'hffffffff, 2'h0);
		rd(4'h4, 32'h3ff, 2'h0);
		cyc(3);
		chk_val("cfg", 32'h7fff, {15'h0, cfg});
		chk_val("pad", 32'h0, {28'h0, pad});
		$display("registers test done");
		for (int s = 0; s < 4; s++) begin
			wr(4'h0, 32'h8000 | (s << 6), 2'h0);
			cyc(3);
			chk_val("pad", 32'h1 << s, {28'h0, pad});
			chk_val("cfg", 32'h183ff | (s << 13), {15'h0, cfg});
		end
		$display("select test done");
		wr(4'h0, 32'h8000, 2'h0);
		cmp_raw_i <= 1'b1;
		@(posedge mclk_i);
		cmp_raw_i <= 1'b0;
		cyc(8);
		chk_val("glitch", 32'h0, {31'h0, filt} | pulses);
		cmp_raw_i <= 1'b1;
		wait_filt(1'b1);
		cyc(3);
		chk_val("pulses", 32'h1, pulses);
		rd(4'h0, 32'h8008, 2'h0);
		wr(4'h0, 32'h8002, 2'h0);
		wait_filt(1'b0);
		rd(4'h0, 32'h8002, 2'h0);
		cmp_raw_i <= 1'b0;
		wait_filt(1'b1);
		cyc(3);
		chk_val("pulses", 32'h2, pulses);
		$display("events test done");
		sleep_i <= 1'b1;
		@(negedge mclk_i);
		chk_val("wake", 32'h1, {31'h0, wake});
		@(posedge mclk_i);
		sleep_i <= 1'b0;
		idle_i <= 1'b1;
		@(negedge mclk_i);
		chk_val("wake", 32'h1, {31'h0, wake});
		wr(4'h0, 32'ha002, 2'h0);
		cyc(3);
		chk_val("stop", 32'h4, {29'h0, stop_o, cfg.cmp_power, wake});
		wr(4'h0, 32'h8002, 2'h0);
		group_stop_i <= 1'b1;
		cyc(3);
		chk_val("group", 32'h0, {30'h0, stop_o, cfg.cmp_power});
		group_stop_i <= 1'b0;
		cyc(3);
		chk_val("group", 32'h1, {30'h0, stop_o, cfg.cmp_power});
		idle_i <= 1'b0;
		$display("idle test done");
		wr(4'h0, 32'h0, 2'h0);
		cyc(6);
		base = pulses;
		chk_val("power", 32'h0, {30'h0, cfg.cmp_power, cfg.dac_power});
		cmp_raw_i <= 1'b1;
		cyc(10);
		chk_val("pulses", base, pulses);
		$display("disable test done");
		tally_and_finish();
	end
	initial begin
		cyc(20000);
		err_count++;
		tally_and_finish();
	end
endmodule

/* verilog/cmpd_glitch_filter.sv */
// Glitch filter: output follows the input only after it has held for FILT_CYCLES samples.
// Assumes a synchronised input and a reset already synchronised to mclk_i.
`include "cmpd_params.svh"

module cmpd_glitch_filter #(
	parameter int unsigned FILT_CYCLES = `CMPD_FILT_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic level_i,
	output logic level_o
);

	cmpd_pkg::cmpd_flt_state_t s_q;
	cmpd_pkg::cmpd_flt_state_t s_d;

	if (FILT_CYCLES < 2 || FILT_CYCLES > `CMPD_FILT_MAX) begin : g_chk
		$error("FILT_CYCLES out of range");
	end

	always_comb begin
		s_d = s_q;
		if (level_i == s_q.level) begin
			s_d.cnt = 4'h0;
		end else if (s_q.cnt == 4'(FILT_CYCLES - 1)) begin
			s_d.level = level_i;
			s_d.cnt = 4'h0;
		end else begin
			s_d.cnt = s_q.cnt + 4'h1;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.level;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	AST_NO_SHORT_GLITCH: assert property ($changed(s_q.level) |->
		($past(level_i) == s_q.level) && ($past(level_i, 2) == s_q.level))
		else $error("filter passed a level shorter than the filter time");

endmodule

/* verilog/cmpd_params.svh */
// Constants for the comparator digital control block: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CMPD_PARAMS_SVH
`define CMPD_PARAMS_SVH

`define CMPD_ADDR_W 4
`define CMPD_OFF_CTRL 4'h0
`define CMPD_OFF_REF 4'h4

`define CMPD_CTRL_EN 15
`define CMPD_CTRL_SIDL 13
`define CMPD_CTRL_DAC_PIN_ENABLE_BIT 8
`define CMPD_CTRL_INSEL_HI 7
`define CMPD_CTRL_INSEL_LO 6
`define CMPD_CTRL_EXTERNAL_REFERENCE_SELECT 5
`define CMPD_CTRL_STAT 3
`define CMPD_CTRL_POL 1
`define CMPD_CTRL_RANGE 0

`define CMPD_CTRL_WMASK 16'ha1e3
`define CMPD_CTRL_RSVD 16'h5e14
`define CMPD_REF_WMASK 16'h03ff
`define CMPD_CTRL_RESET 16'h0000
`define CMPD_REF_RESET 16'h0000

`define CMPD_RESP_OKAY 2'h0
`define CMPD_RESP_SLVERR 2'h2

`define CMPD_FILT_CYCLES 2
`define CMPD_FILT_MAX 16

`endif

/* verilog/cmpd_pkg.sv */
// Types for the comparator digital control block.
// Assumes cmpd_params.svh supplies the numeric constants.
`include "cmpd_params.svh"

package cmpd_pkg;

	typedef struct packed {
		logic cmp_power;
		logic dac_power;
		logic [1:0] input_select;
		logic ext_ref_sel;
		logic high_range;
		logic dac_pin_enable;
		logic [9:0] ref_code;
	} cmpd_analog_t;

	typedef struct packed {
		logic level;
		logic [3:0] cnt;
	} cmpd_flt_state_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] refc;
		logic sync1;
		logic sync2;
		logic filt_prev;
		logic active;
		logic irq;
		logic adc;
		logic stop_out;
		logic [3:0] pad_dis;
		cmpd_analog_t ana;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_hold;
		logic w_hold;
		logic [`CMPD_ADDR_W-1:0] awaddr;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [15:0] rdata;
	} cmpd_state_t;

endpackage

/* verilog/cmpd_top.sv */
// Comparator digital control: AXI4-Lite registers, synchroniser, glitch filter, event pulses.
// Assumes a raw asynchronous comparator level and same-clock sleep/idle levels.
`include "cmpd_params.svh"

module cmpd_top #(
	parameter int unsigned FILT_CYCLES = `CMPD_FILT_CYCLES
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic cmp_raw_i,
	input wire logic sleep_i,
	input wire logic idle_i,
	input wire logic group_stop_i,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`CMPD_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [`CMPD_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output cmpd_pkg::cmpd_analog_t analog_cfg_o,
	output logic [3:0] pad_dig_disable_o,
	output logic stop_in_idle_o,
	output logic filtered_o,
	output logic irq_pulse_o,
	output logic adc_trig_o,
	output logic pwm_fault_o,
	output logic wake_async_o
);

	logic [1:0] rst_sync_q;
	logic rst_n;
	logic flt_in;
	logic flt;
	logic mode_lp;
	cmpd_pkg::cmpd_state_t s_q;
	cmpd_pkg::cmpd_state_t s_d;

	// Write merge per byte lane; bits outside the mask stay zero
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] data,
		input logic [1:0] strb, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v & mask;
	endfunction

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Disabled module feeds a steady zero so no stale edge survives re-enable
	assign flt_in = s_q.active & (s_q.sync2 ^ s_q.ctrl[`CMPD_CTRL_POL]);

	cmpd_glitch_filter #(
		.FILT_CYCLES(FILT_CYCLES)
	) u_filter (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.level_i(flt_in),
		.level_o(flt)
	);

	always_comb begin
		s_d = s_q;
		s_d.sync1 = cmp_raw_i;
		s_d.sync2 = s_q.sync1;
		s_d.active = s_q.ctrl[`CMPD_CTRL_EN] &
			!(idle_i & (s_q.ctrl[`CMPD_CTRL_SIDL] | group_stop_i));
		s_d.stop_out = s_q.ctrl[`CMPD_CTRL_SIDL];
		s_d.filt_prev = flt;
		s_d.irq = s_q.active & flt & !s_q.filt_prev;
		s_d.adc = s_q.active & flt & !s_q.filt_prev;
		s_d.ana.cmp_power = s_d.active;
		s_d.ana.dac_power = s_d.active;
		s_d.ana.input_select = s_q.ctrl[`CMPD_CTRL_INSEL_HI:`CMPD_CTRL_INSEL_LO];
		s_d.ana.ext_ref_sel = s_q.ctrl[`CMPD_CTRL_EXTERNAL_REFERENCE_SELECT];
		s_d.ana.high_range = s_q.ctrl[`CMPD_CTRL_RANGE];
		s_d.ana.dac_pin_enable = s_q.ctrl[`CMPD_CTRL_DAC_PIN_ENABLE_BIT];
		s_d.ana.ref_code = s_q.refc[9:0];
		for (int i = 0; i < 4; i++) begin
			s_d.pad_dis[i] = s_q.ctrl[`CMPD_CTRL_EN] &
				(s_q.ctrl[`CMPD_CTRL_INSEL_HI:`CMPD_CTRL_INSEL_LO] == 2'(i));
		end

		// Write address and data may arrive in either order
		if (s_q.awready && s_axi_awvalid) begin
			s_d.aw_hold = 1'h1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_q.wready && s_axi_wvalid) begin
			s_d.w_hold = 1'h1;
			s_d.wdata = s_axi_wdata[15:0];
			s_d.wstrb = s_axi_wstrb[1:0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'h0;
		end
		if (s_q.aw_hold && s_q.w_hold && !s_q.bvalid) begin
			s_d.aw_hold = 1'h0;
			s_d.w_hold = 1'h0;
			s_d.bvalid = 1'h1;
			s_d.bresp = `CMPD_RESP_OKAY;
			case (s_q.awaddr)
				`CMPD_OFF_CTRL: begin
					s_d.ctrl = wr16(s_q.ctrl, s_q.wdata, s_q.wstrb, `CMPD_CTRL_WMASK);
				end
				`CMPD_OFF_REF: begin
					s_d.refc = wr16(s_q.refc, s_q.wdata, s_q.wstrb, `CMPD_REF_WMASK);
				end
				default: begin
					s_d.bresp = `CMPD_RESP_SLVERR;
				end
			endcase
		end
		s_d.awready = !s_d.aw_hold && !s_d.bvalid;
		s_d.wready = !s_d.w_hold && !s_d.bvalid;

		// Read side: one outstanding read, answered the cycle after the address
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'h0;
		end
		if (s_q.arready && s_axi_arvalid) begin
			s_d.rvalid = 1'h1;
			s_d.rresp = `CMPD_RESP_OKAY;
			case (s_axi_araddr)
				`CMPD_OFF_CTRL: begin
					s_d.rdata = s_q.ctrl;
					s_d.rdata[`CMPD_CTRL_STAT] = flt;
				end
				`CMPD_OFF_REF: begin
					s_d.rdata = s_q.refc;
				end
				default: begin
					s_d.rdata = 16'h0000;
					s_d.rresp = `CMPD_RESP_SLVERR;
				end
			endcase
		end
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// The wake path must work with the clock stopped, so it bypasses the synchroniser and filter; its only flops are config and the running flag
	assign mode_lp = sleep_i | idle_i;
	assign wake_async_o = mode_lp & s_q.active & (cmp_raw_i ^ s_q.ctrl[`CMPD_CTRL_POL]);

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = {16'h0000, s_q.rdata};
	assign analog_cfg_o = s_q.ana;
	assign pad_dig_disable_o = s_q.pad_dis;
	assign stop_in_idle_o = s_q.stop_out;
	assign filtered_o = flt;
	assign irq_pulse_o = s_q.irq;
	assign adc_trig_o = s_q.adc;
	assign pwm_fault_o = flt;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	sequence s_in_steady;
		($stable(s_q.sync2) && $stable(s_q.ctrl[`CMPD_CTRL_POL]) && s_q.active)[*3];
	endsequence

	sequence s_low_glitch;
		(!flt && !flt_in) ##1 flt_in ##1 !flt_in;
	endsequence

	sequence s_high_glitch;
		(flt && flt_in) ##1 !flt_in ##1 flt_in;
	endsequence

	AST_PULSE_ONE_CYCLE: assert property (s_q.irq |=> !s_q.irq)
		else $error("interrupt pulse longer than one cycle");

	AST_PULSE_SHARED: assert property (s_q.irq == s_q.adc)
		else $error("interrupt and ADC trigger pulses disagree");

	AST_PULSE_ON_RISE: assert property (s_q.irq |->
		s_q.filt_prev && !$past(s_q.filt_prev) && $past(s_q.active))
		else $error("pulse without a rising filtered edge while running");

	AST_POLARITY_PATH: assert property (s_in_steady |->
		flt == (s_q.sync2 ^ s_q.ctrl[`CMPD_CTRL_POL]))
		else $error("filtered level does not follow polarity-adjusted input");

	AST_RSVD_ZERO: assert property ((s_q.ctrl & `CMPD_CTRL_RSVD) == 16'h0000 &&
		(s_q.refc & ~`CMPD_REF_WMASK) == 16'h0000 && s_axi_rdata[31:16] == 16'h0000)
		else $error("reserved bit not zero");

	AST_RESET_CLEAR: assert property ($rose(rst_n) |->
		s_q.ctrl == `CMPD_CTRL_RESET && s_q.refc == `CMPD_REF_RESET)
		else $error("registers not cleared by reset");

	// Power mirrors the running flag in the same register stage, so both drop together
	AST_IDLE_STOP: assert property (idle_i && s_q.ctrl[`CMPD_CTRL_SIDL] |=>
		!s_q.active && !analog_cfg_o.cmp_power)
		else $error("comparator kept running in idle with stop bit set");

	AST_GROUP_STOP: assert property (idle_i && group_stop_i |=>
		!analog_cfg_o.cmp_power && !analog_cfg_o.dac_power)
		else $error("group stop in idle ignored");

	AST_DISABLE_POWER: assert property (!s_q.ctrl[`CMPD_CTRL_EN] |=>
		!analog_cfg_o.cmp_power && !analog_cfg_o.dac_power ##1 !s_q.irq)
		else $error("disabled module still powered");

	AST_PAD_BUFFER: assert property (s_q.ctrl[`CMPD_CTRL_EN] &&
		$stable(s_q.ctrl) |=> $onehot(pad_dig_disable_o))
		else $error("selected pad buffer not disabled");

	AST_BRESP_HOLD: assert property (s_q.bvalid && !s_axi_bready |=>
		s_q.bvalid && $stable(s_q.bresp))
		else $error("write response dropped before handshake");

	AST_RDATA_HOLD: assert property (s_q.rvalid && !s_axi_rready |=>
		s_q.rvalid && $stable(s_q.rdata))
		else $error("read data dropped before handshake");

	AST_GLITCH_LOW: assert property (s_low_glitch |=> !flt)
		else $error("one-cycle high glitch reached the filtered level");

	AST_GLITCH_HIGH: assert property (s_high_glitch |=> flt)
		else $error("one-cycle low glitch reached the filtered level");

	AST_SYNC_TWO_FLOP: assert property ($past(rst_n, 2) |->
		s_q.sync2 == $past(cmp_raw_i, 2))
		else $error("comparator level not delayed by two synchroniser flops");

	AST_NO_PULSE_STOPPED: assert property (!s_q.active |=> !s_q.irq && !s_q.adc)
		else $error("event pulse while the comparator is stopped");

	AST_CFG_SELECT: assert property (
		analog_cfg_o.input_select == $past(s_q.ctrl[`CMPD_CTRL_INSEL_HI:`CMPD_CTRL_INSEL_LO]))
		else $error("input select not passed to the analog side");

	AST_CFG_REFERENCE: assert property (
		analog_cfg_o.ext_ref_sel == $past(s_q.ctrl[`CMPD_CTRL_EXTERNAL_REFERENCE_SELECT]) &&
		analog_cfg_o.high_range == $past(s_q.ctrl[`CMPD_CTRL_RANGE]) &&
		analog_cfg_o.ref_code == $past(s_q.refc[9:0]))
		else $error("reference settings not passed to the analog side");

	AST_DAC_PIN: assert property (
		analog_cfg_o.dac_pin_enable == $past(s_q.ctrl[`CMPD_CTRL_DAC_PIN_ENABLE_BIT]))
		else $error("DAC pin enable not passed to the analog side");

	AST_STOP_EXPORT: assert property (
		stop_in_idle_o == $past(s_q.ctrl[`CMPD_CTRL_SIDL]))
		else $error("own stop-in-idle bit not exported to the group");

	AST_RUN_IN_IDLE: assert property (s_q.ctrl[`CMPD_CTRL_EN] &&
		!s_q.ctrl[`CMPD_CTRL_SIDL] && !group_stop_i |=> s_q.active)
		else $error("comparator stopped although no stop bit is set");

	AST_PAD_OFF: assert property (!s_q.ctrl[`CMPD_CTRL_EN] |=>
		pad_dig_disable_o == 4'h0)
		else $error("pad buffer disabled while the module is off");

	AST_STATUS_READ: assert property (
		$rose(s_q.rvalid) && $past(s_axi_araddr) == `CMPD_OFF_CTRL |->
		s_axi_rdata[`CMPD_CTRL_STAT] == $past(flt))
		else $error("status bit does not show the filtered level");

endmodule
